//--- src/gtcc_pkg.sv
// shared constants and types for the global timer and channel configuration block
package gtcc_pkg;
  localparam int GTCC_NCH = 8;
  localparam logic [7:0] GTCC_ADDR_SRC1 = 8'h81;
  localparam logic [7:0] GTCC_ADDR_SRC2 = 8'h82;
  localparam logic [7:0] GTCC_ADDR_SRC3 = 8'h83;
  localparam logic [7:0] GTCC_ADDR_TCMD = 8'h84;
  localparam logic [7:0] GTCC_ADDR_TRSV = 8'h85;
  localparam logic [7:0] GTCC_ADDR_TLOW = 8'h86;
  localparam logic [7:0] GTCC_ADDR_THIGH = 8'h87;
  localparam logic [7:0] GTCC_ADDR_X8 = 8'h88;
  localparam logic [7:0] GTCC_ADDR_X4 = 8'h89;
  localparam logic [7:0] GTCC_ADDR_CRST = 8'h8A;
  localparam logic [7:0] GTCC_ZERO8 = 8'h00;
  localparam logic [7:0] GTCC_TIRQ_READ = 8'h01;
  localparam logic [15:0] GTCC_TERM_RESET = 16'h0000;
  localparam logic [15:0] GTCC_COUNT_ONE = 16'h0001;
  localparam logic [3:0] GTCC_CMD_IRQ_EN = 4'h1;
  localparam logic [3:0] GTCC_CMD_IRQ_DIS = 4'h2;
  localparam logic [3:0] GTCC_CMD_ONESHOT = 4'h3;
  localparam logic [3:0] GTCC_CMD_RETRIG = 4'h4;
  localparam logic [3:0] GTCC_CMD_CLK_INT = 4'h5;
  localparam logic [3:0] GTCC_CMD_CLK_EXT = 4'h6;
  localparam logic [3:0] GTCC_CMD_START = 4'h9;
  localparam logic [3:0] GTCC_CMD_STOP = 4'hA;
  localparam logic [3:0] GTCC_CMD_RESET = 4'hB;
  localparam logic [2:0] GTCC_SRC_NONE = 3'h0;
  localparam logic [2:0] GTCC_SRC_RX = 3'h1;
  localparam logic [2:0] GTCC_SRC_RXTO = 3'h2;
  localparam logic [2:0] GTCC_SRC_TX = 3'h3;
  localparam logic [2:0] GTCC_SRC_MODEM = 3'h4;
  localparam logic [2:0] GTCC_SRC_TIMER = 3'h7;
  typedef enum logic [1:0] {
    GTCC_RATE_16X = 2'h0,
    GTCC_RATE_8X = 2'h1,
    GTCC_RATE_4X = 2'h2
  } gtcc_rate_e;
  // per-channel pending sources, already reduced by the channel datapath
  typedef struct packed {
    logic rx_ready;
    logic line_status;
    logic rx_timeout;
    logic tx_empty;
    logic modem_delta;
    logic flow_char;
  } gtcc_src_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gtcc_bus_s;
endpackage

//--- src/gtcc_src_enc.sv
// per-channel interrupt source priority encoder
`timescale 1ns/1ps
module gtcc_src_enc (
  input wire gtcc_pkg::gtcc_src_s src,
  input wire logic timer_irq,
  output logic [2:0] code
);
  import gtcc_pkg::*;
  wire rx_any = src.rx_ready | src.line_status;
  wire modem_any = src.modem_delta | src.flow_char;
  // priority 1 highest; timer last since it sits at the bottom of the order
  assign code = rx_any ? GTCC_SRC_RX :
                src.rx_timeout ? GTCC_SRC_RXTO :
                src.tx_empty ? GTCC_SRC_TX :
                modem_any ? GTCC_SRC_MODEM :
                timer_irq ? GTCC_SRC_TIMER :
                GTCC_SRC_NONE;
endmodule

//--- src/gtcc_rate_sel.sv
// per-channel sampling rate selection
`timescale 1ns/1ps
module gtcc_rate_sel (
  input wire logic x8,
  input wire logic x4,
  output gtcc_pkg::gtcc_rate_e rate
);
  import gtcc_pkg::*;
  // 4x wins when both bits are set
  assign rate = x4 ? GTCC_RATE_4X : (x8 ? GTCC_RATE_8X : GTCC_RATE_16X);
endmodule

//--- src/gtcc_top.sv
// global timer/counter, channel source codes, sampling and soft reset registers
// Summary of operation
// - code 000 when nothing pending or wake-up
// - code 001 receive ready or line errors
// - code 010 receive time-out, cleared like receive
// - code 011 transmit empty, cleared by status read
// - code 100 modem delta or flow character
// - code 111 timer, channel 0 only
// - timer counts crystal or external pin
// - terminal value from two bytes, reads programmed
// - commands self-clear, never read back
// - control read shows pending, then clears it
// - commands enable/disable timer interrupt, default disabled
// - one-shot or re-triggerable, default re-triggerable
// - start, stop, reset; other codes ignored
// - reset: stopped, count back to one, pending cleared; enable, mode, clock kept
// - one-shot interrupts once after N clocks
// - re-triggerable interrupts every N clocks
// - 8x bit selects 8x sampling unless the 4x bit is also set
// - 4x bit selects 4x sampling
// - channel reset bit pulses then self-clears
// - source codes packed 24 bits, channel 0 lowest
`timescale 1ns/1ps
module gtcc_top #(
  parameter int NCH = gtcc_pkg::GTCC_NCH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire gtcc_pkg::gtcc_bus_s bus,
  output logic [7:0] rdata,
  input wire gtcc_pkg::gtcc_src_s [NCH-1:0] chan_src,
  input wire logic external_timer_clock_pin,
  output logic timer_irq,
  output logic [NCH*3-1:0] source_codes,
  output gtcc_pkg::gtcc_rate_e [NCH-1:0] chan_rate,
  output logic [NCH-1:0] chan_reset
);
  import gtcc_pkg::*;

  logic [7:0] timer_count_low_reg;
  logic [7:0] timer_count_high_reg;
  logic [NCH-1:0] x8_reg;
  logic [NCH-1:0] x4_reg;
  logic [NCH-1:0] crst_reg;
  logic irq_en_reg;
  logic oneshot_reg;
  logic ext_clk_reg;
  logic run_reg;
  logic pend_reg;
  logic [15:0] count_reg;
  logic [7:0] rdata_reg;
  logic tck_s1_reg;
  logic tck_s2_reg;
  logic tck_s3_reg;

  // bus decode
  wire wr_low = bus.wr && bus.addr == GTCC_ADDR_TLOW;
  wire wr_high = bus.wr && bus.addr == GTCC_ADDR_THIGH;
  wire wr_x8 = bus.wr && bus.addr == GTCC_ADDR_X8;
  wire wr_x4 = bus.wr && bus.addr == GTCC_ADDR_X4;
  wire wr_crst = bus.wr && bus.addr == GTCC_ADDR_CRST;
  wire wr_cmd = bus.wr && bus.addr == GTCC_ADDR_TCMD;
  wire rd_cmd = bus.rd && bus.addr == GTCC_ADDR_TCMD;
  wire [3:0] cmd = bus.wdata[3:0];
  wire cmd_en = wr_cmd && cmd == GTCC_CMD_IRQ_EN;
  wire cmd_dis = wr_cmd && cmd == GTCC_CMD_IRQ_DIS;
  wire cmd_one = wr_cmd && cmd == GTCC_CMD_ONESHOT;
  wire cmd_retrig = wr_cmd && cmd == GTCC_CMD_RETRIG;
  wire cmd_cint = wr_cmd && cmd == GTCC_CMD_CLK_INT;
  wire cmd_cext = wr_cmd && cmd == GTCC_CMD_CLK_EXT;
  wire cmd_start = wr_cmd && cmd == GTCC_CMD_START;
  wire cmd_stop = wr_cmd && cmd == GTCC_CMD_STOP;
  wire cmd_reset = wr_cmd && cmd == GTCC_CMD_RESET;
  wire [15:0] term = {timer_count_high_reg, timer_count_low_reg};

  // timer tick: crystal every enabled cycle, pin on a synchronised rising edge
  wire ext_rise = tck_s2_reg && !tck_s3_reg;
  wire tick = ext_clk_reg ? ext_rise : 1'b1;
  // count starts at one so the time-out lands on the Nth tick after start
  wire hit = run_reg && tick && count_reg >= term;
  wire pend_next = hit | (pend_reg & ~rd_cmd);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tck_s1_reg <= 1'b0;
      tck_s2_reg <= 1'b0;
      tck_s3_reg <= 1'b0;
    end else if (clk_en) begin
      tck_s1_reg <= external_timer_clock_pin;
      tck_s2_reg <= tck_s1_reg;
      tck_s3_reg <= tck_s2_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      timer_count_low_reg <= GTCC_ZERO8;
      timer_count_high_reg <= GTCC_ZERO8;
      x8_reg <= '0;
      x4_reg <= '0;
    end else if (clk_en) begin
      if (wr_low) begin
        timer_count_low_reg <= bus.wdata;
      end
      if (wr_high) begin
        timer_count_high_reg <= bus.wdata;
      end
      if (wr_x8) begin
        x8_reg <= bus.wdata[NCH-1:0];
      end
      if (wr_x4) begin
        x4_reg <= bus.wdata[NCH-1:0];
      end
    end
  end

  // soft reset bits live one cycle then clear
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      crst_reg <= '0;
    end else if (clk_en) begin
      crst_reg <= wr_crst ? bus.wdata[NCH-1:0] : '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq_en_reg <= 1'b0;
      oneshot_reg <= 1'b0;
      ext_clk_reg <= 1'b0;
      run_reg <= 1'b0;
    end else if (clk_en) begin
      if (cmd_en) irq_en_reg <= 1'b1;
      if (cmd_dis) irq_en_reg <= 1'b0;
      if (cmd_one) oneshot_reg <= 1'b1;
      if (cmd_retrig) oneshot_reg <= 1'b0;
      if (cmd_cint) ext_clk_reg <= 1'b0;
      if (cmd_cext) ext_clk_reg <= 1'b1;
      if (cmd_start) begin
        run_reg <= 1'b1;
      end else if (cmd_stop || cmd_reset || (hit && oneshot_reg)) begin
        run_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      count_reg <= GTCC_COUNT_ONE;
      pend_reg <= 1'b0;
    end else if (clk_en) begin
      if (cmd_start || cmd_reset || hit) begin
        count_reg <= GTCC_COUNT_ONE;
      end else if (run_reg && tick) begin
        count_reg <= count_reg + GTCC_COUNT_ONE;
      end
      // new time-out wins over a clearing read in the same cycle
      pend_reg <= cmd_reset ? 1'b0 : pend_next;
    end
  end

  // read data: commands are never stored, so the control read shows only pending
  wire [7:0] rd_cmd_val = pend_reg ? GTCC_TIRQ_READ : GTCC_ZERO8;
  // size casts zero-extend; a zero replication count would break the full-width build
  wire [23:0] codes24 = 24'(source_codes);
  wire [7:0] x8_rd = 8'(x8_reg);
  wire [7:0] x4_rd = 8'(x4_reg);
  wire [7:0] rd_mux =
    bus.addr == GTCC_ADDR_SRC1 ? codes24[7:0] :
    bus.addr == GTCC_ADDR_SRC2 ? codes24[15:8] :
    bus.addr == GTCC_ADDR_SRC3 ? codes24[23:16] :
    bus.addr == GTCC_ADDR_TCMD ? rd_cmd_val :
    bus.addr == GTCC_ADDR_TLOW ? timer_count_low_reg :
    bus.addr == GTCC_ADDR_THIGH ? timer_count_high_reg :
    bus.addr == GTCC_ADDR_X8 ? x8_rd :
    bus.addr == GTCC_ADDR_X4 ? x4_rd :
    GTCC_ZERO8;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_reg <= GTCC_ZERO8;
    end else if (clk_en && bus.rd) begin
      rdata_reg <= rd_mux;
    end
  end

  assign rdata = rdata_reg;
  assign timer_irq = pend_reg && irq_en_reg;
  assign chan_reset = crst_reg;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      gtcc_src_enc u_enc (
        .src(chan_src[g]),
        .timer_irq(g == 0 ? timer_irq : 1'b0),
        .code(source_codes[g*3 +: 3])
      );
      gtcc_rate_sel u_rate (
        .x8(x8_reg[g]),
        .x4(x4_reg[g]),
        .rate(chan_rate[g])
      );
    end
  endgenerate
endmodule

//--- verif/gtcc_top_monitor.sv
// assertion checker for the timer and channel configuration block
`timescale 1ns/1ps
module gtcc_top_monitor #(
  parameter int NCH = gtcc_pkg::GTCC_NCH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire gtcc_pkg::gtcc_bus_s bus,
  input wire logic [7:0] rdata,
  input wire gtcc_pkg::gtcc_src_s [NCH-1:0] chan_src,
  input wire logic external_timer_clock_pin,
  input wire logic timer_irq,
  input wire logic [NCH*3-1:0] source_codes,
  input wire gtcc_pkg::gtcc_rate_e [NCH-1:0] chan_rate,
  input wire logic [NCH-1:0] chan_reset
);
  import gtcc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_rd(a); clk_en && bus.rd && bus.addr == a; endsequence
  sequence s_wr(a); clk_en && bus.wr && bus.addr == a; endsequence
  property p_rst; $rose(nrst) |-> !timer_irq && chan_reset == '0 && rdata == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  property p_idle0; chan_src[0] == '0 && !timer_irq |-> source_codes[2:0] == 3'h0; endproperty
  a_idle0: assert property (p_idle0) else $error("idle code wrong");
  property p_rx1; chan_src[1].rx_ready || chan_src[1].line_status |-> source_codes[5:3] == 3'h1;
  endproperty
  a_rx1: assert property (p_rx1) else $error("receive code wrong");
  property p_tsrc; timer_irq && chan_src[0] == '0 |-> source_codes[2:0] == 3'h7; endproperty
  a_tsrc: assert property (p_tsrc) else $error("timer code wrong");
  property p_tread; s_rd(GTCC_ADDR_TCMD) |=> rdata[7:1] == 7'h00; endproperty
  a_tread: assert property (p_tread) else $error("command echoed");
  property p_tpend; s_rd(GTCC_ADDR_TCMD) ##0 timer_irq |=> rdata == 8'h01; endproperty
  a_tpend: assert property (p_tpend) else $error("pending not read");
  property p_x4; s_wr(GTCC_ADDR_X4) ##0 bus.wdata[0] |=> chan_rate[0] == GTCC_RATE_4X; endproperty
  a_x4: assert property (p_x4) else $error("4x not taken");
  property p_crst; s_wr(GTCC_ADDR_CRST) |=> chan_reset == $past(bus.wdata[NCH-1:0]); endproperty
  a_crst: assert property (p_crst) else $error("channel reset wrong");
endmodule
bind gtcc_top gtcc_top_monitor #(.NCH(NCH)) i_gtcc_top_monitor (.mclk(mclk), .nrst(nrst),
  .clk_en(clk_en), .bus(bus), .rdata(rdata), .chan_src(chan_src),
  .external_timer_clock_pin(external_timer_clock_pin), .timer_irq(timer_irq),
  .source_codes(source_codes), .chan_rate(chan_rate), .chan_reset(chan_reset));

//--- verif/gtcc_host.sv
// host processor model on the register bus
`timescale 1ns/1ps
module gtcc_host (
  input wire logic mclk,
  output gtcc_pkg::gtcc_bus_s bus,
  input wire logic [7:0] rdata
);
  import gtcc_pkg::*;
  initial bus = '0;
  // released lines show inverted values so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    bus <= '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    bus <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    bus <= '{1'b0, 1'b0, ~a, 8'hFF};
    d = rdata;
  endtask
endmodule

//--- verif/tb_gtcc_top.sv
// self-checking bench for the timer and channel configuration block
`timescale 1ns/1ps
module tb_gtcc_top;
  import gtcc_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic ext_pin = 1'b0;
  gtcc_bus_s bus;
  gtcc_src_s [7:0] chan_src = '0;
  logic [7:0] rdata, rv;
  logic timer_irq;
  logic [23:0] source_codes;
  gtcc_rate_e [7:0] chan_rate;
  logic [7:0] chan_reset;
  int err_count = 0;
  int checks = 0;
  always #25 mclk = ~mclk;
  gtcc_host i_gtcc_host (.mclk(mclk), .bus(bus), .rdata(rdata));
  gtcc_top i_gtcc_top (.mclk(mclk), .nrst(nrst), .clk_en(1'b1), .bus(bus), .rdata(rdata),
    .chan_src(chan_src), .external_timer_clock_pin(ext_pin), .timer_irq(timer_irq),
    .source_codes(source_codes), .chan_rate(chan_rate), .chan_reset(chan_reset));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_gtcc_host.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_gtcc_host.wr(a, d);
  endtask
  task automatic cmd(input logic [3:0] c);
    w(GTCC_ADDR_TCMD, {4'h0, c});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // interrupt must appear exactly n cycles after this task is entered
  task automatic hit(input int n);
    cyc(n - 1);
    chk(timer_irq, 1'b0);
    cyc(1);
    chk(timer_irq, 1'b1);
  endtask
  task automatic complete_run;
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    complete_run;
  end
  initial begin
    cyc(6);
    nrst <= 1'b1;
    rchk(GTCC_ADDR_TCMD, 8'h00);
    rchk(GTCC_ADDR_THIGH, 8'h00);
    chk({8'h00, chan_rate}, 24'h0);
    rchk(8'h80, 8'h00);
    rchk(GTCC_ADDR_TRSV, 8'h00);
    chan_src <= {6'h04, 6'h00, 6'h10, 6'h02, 6'h01, 6'h06, 6'h0C, 6'h3F};
    cyc(1);
    chk(source_codes, 24'h60C8D1);
    rchk(GTCC_ADDR_SRC1, 8'hD1);
    rchk(GTCC_ADDR_SRC3, 8'h60);
    chan_src <= '0;
    w(GTCC_ADDR_X8, 8'h0F);
    w(GTCC_ADDR_X4, 8'h33);
    chk({8'h00, chan_rate}, 24'h0A5A);
    rchk(GTCC_ADDR_X8, 8'h0F);
    w(GTCC_ADDR_CRST, 8'h81);
    chk(chan_reset, 8'h81);
    cyc(1);
    chk(chan_reset, 8'h00);
    w(GTCC_ADDR_THIGH, 8'hA5);
    w(GTCC_ADDR_TLOW, 8'h05);
    rchk(GTCC_ADDR_THIGH, 8'hA5);
    w(GTCC_ADDR_THIGH, 8'h00);
    cmd(GTCC_CMD_START);
    cyc(12);
    chk(timer_irq, 1'b0);
    rchk(GTCC_ADDR_TLOW, 8'h05);
    cmd(GTCC_CMD_IRQ_EN);
    chk(timer_irq, 1'b1);
    cmd(GTCC_CMD_STOP);
    rchk(GTCC_ADDR_TCMD, 8'h01);
    rchk(GTCC_ADDR_TCMD, 8'h00);
    cmd(GTCC_CMD_START);
    hit(5);
    rchk(GTCC_ADDR_TCMD, 8'h01);
    hit(3);
    cmd(GTCC_CMD_RESET);
    cyc(12);
    chk(timer_irq, 1'b0);
    cmd(GTCC_CMD_ONESHOT);
    // reserved codes must neither start the timer nor change its mode
    for (int c = 7; c < 16; c++) if (c < 9 || c > 11) cmd(4'(c));
    cmd(GTCC_CMD_START);
    hit(5);
    rchk(GTCC_ADDR_TCMD, 8'h01);
    cyc(12);
    chk(timer_irq, 1'b0);
    w(GTCC_ADDR_TLOW, 8'h02);
    cmd(GTCC_CMD_CLK_EXT);
    cmd(GTCC_CMD_START);
    for (int i = 0; i < 2; i++) begin
      cyc(8);
      chk(timer_irq, 1'b0);
      ext_pin <= 1'b1;
      cyc(2);
      ext_pin <= 1'b0;
    end
    cyc(6);
    chk(timer_irq, 1'b1);
    cmd(GTCC_CMD_IRQ_DIS);
    chk(timer_irq, 1'b0);
    rchk(GTCC_ADDR_TCMD, 8'h01);
    cmd(GTCC_CMD_CLK_INT);
    cmd(GTCC_CMD_IRQ_EN);
    cmd(GTCC_CMD_START);
    hit(2);
    complete_run;
  end
endmodule
